// [src/fcl_pkg.sv]
// package: constants, types and helpers for the flash config loader
package fcl_pkg;

  localparam int WORD_W   = 32;
  localparam int ADDR_W   = 12;
  localparam int SEL_W    = 5;
  localparam int TAG_AW   = 7;
  localparam int IDX_W    = 5;

  // image layout: header word, payload words, crc word
  localparam logic [IDX_W-1:0]  IMG_LAST  = 5'h0F;
  localparam logic [IDX_W-1:0]  PAY_LAST  = 5'h0D;
  localparam logic [ADDR_W-1:0] PRI_BASE  = 12'h000;
  localparam logic [ADDR_W-1:0] BAK_BASE  = 12'h100;
  localparam logic [ADDR_W-1:0] EBR_BASE  = 12'h800;
  localparam int                HDR_VER_LSB = 24;
  localparam int                HDR_ENC_BIT = 8;

  // label memory: 600 bits held as bytes
  localparam int              TAG_BITS  = 600;
  localparam int              TAG_BYTES = TAG_BITS / 8;
  localparam logic [TAG_AW-1:0] TAG_LAST = 7'(TAG_BYTES - 1);

  // frequency selection index into the table below
  localparam logic [SEL_W-1:0] CMCLK_SEL_RST = 5'h01;
  localparam logic [SEL_W-1:0] OSC_SEL_RST   = 5'h00;
  localparam logic [SEL_W-1:0] CMCLK_SEL_MAX = 5'h0E;
  localparam logic [SEL_W-1:0] FREQ_SEL_MAX  = 5'h10;
  localparam int               SYS_CLK_MHZ   = 100;

  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

  typedef enum logic [3:0] {
    OP_NOP, OP_ERASE, OP_PROG, OP_WRITEBACK, OP_LOAD, OP_UNLOCK,
    OP_KEY_LOCK, OP_PERM_LOCK, OP_SET_OTP, OP_TAG_PROG, OP_TAG_READ
  } fcl_op_e;

  typedef enum logic [1:0] {PORT_JTAG, PORT_SSPI, PORT_FABRIC} fcl_port_e;

  typedef enum logic [1:0] {
    SEC_UNLOCKED, SEC_KEY_LOCKED, SEC_PERM_LOCKED
  } fcl_sec_e;

  typedef enum logic [2:0] {
    ST_RD, ST_WAIT, ST_USER, ST_FAIL, ST_SED_RD, ST_SED_WAIT
  } fcl_fsm_e;

  typedef struct packed {
    fcl_op_e          op;
    fcl_port_e        port;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } fcl_cmd_s;

  // frequency in tenths of a MHz for each selection index
  function automatic int fcl_freq_x10(input logic [SEL_W-1:0] sel);
    case (sel)
      5'h00: return 25;
      5'h01: return 31;
      5'h02: return 43;
      5'h03: return 54;
      5'h04: return 69;
      5'h05: return 81;
      5'h06: return 92;
      5'h07: return 100;
      5'h08: return 130;
      5'h09: return 150;
      5'h0A: return 200;
      5'h0B: return 260;
      5'h0C: return 320;
      5'h0D: return 400;
      5'h0E: return 540;
      5'h0F: return 800;
      default: return 1630;
    endcase
  endfunction

  // half period in sys_clk cycles; fastest entries saturate at one
  function automatic logic [5:0] fcl_half_div(input logic [SEL_W-1:0] sel);
    int n;
    n = (SYS_CLK_MHZ * 10) / (2 * fcl_freq_x10(sel));
    if (n < 1) n = 1;
    return 6'(n);
  endfunction

  function automatic logic [31:0] fcl_crc(input logic [31:0] crc,
                                          input logic [31:0] w);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// [src/fcl_clk_div.sv]
// clock divider that makes a slow clock level and a matching tick
`timescale 1ns/1ps
module fcl_clk_div (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic [fcl_pkg::SEL_W-1:0] sel,
  output logic                          clk_lvl,
  output logic                          tick
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       lvl;
    logic       tick;
  } fcl_div_s;

  fcl_div_s st;
  fcl_div_s next_st;

  // never gated by the loader state, so it runs from reset onward
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt + 6'h01 >= fcl_pkg::fcl_half_div(sel)) begin
      next_st.cnt  = 6'h00;
      next_st.lvl  = ~st.lvl;
      next_st.tick = ~st.lvl;
    end else begin
      next_st.cnt = st.cnt + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_lvl = st.lvl;
  assign tick    = st.tick;
endmodule

// [src/fcl_loader.sv]
// configuration loader: boot, security, label memory, soft error scan
// Functional notes
// - copy flash image into config cells at reset and on load command
// - flash program via jtag or slave spi; load from flash or master spi
// - block ram write-back writes only its flash area, no erase
// - security unlocked, key locked or permanent; right key unlocks
// - permanent lock never left; unlock always refused there; code leaves it on reset, which loads the unlocked state
// - one-time-programmable mode refuses all erase and reprogram; code still takes the label program command
// - label memory of 600 bits inside the flash
// - label memory reachable from jtag, slave spi or fabric
// - label read takes start address then streams all bytes in order
// - label memory accessible in every security state
// - decrypt encrypted image with the stored 128-bit key
// - freeze io pins while loading when frozen reconfig is enabled; code freezes only from a reload until user mode, not on the reset load
// - corrupt or wrong-version update image falls back to backup image
// - check image crc during configuration
// - soft error scan only while user logic idle; reload or flag
// - oscillator and master clock run always, visible to fabric
// - master clock starts at default, changes after header clock bits
// - two fastest frequencies only for fabric oscillator
`timescale 1ns/1ps
module fcl_loader (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       cmd_valid,
  input  wire fcl_pkg::fcl_cmd_s          cmd,
  output logic                            cmd_ack,
  output logic                            cmd_refused,
  output logic                            flash_rd_en,
  output logic [fcl_pkg::ADDR_W-1:0]      flash_rd_addr,
  input  wire logic [fcl_pkg::WORD_W-1:0] flash_rd_data,
  input  wire logic                       flash_rd_valid,
  output logic                            boot_ext,
  output logic                            flash_wr_en,
  output logic                            flash_erase,
  output logic [fcl_pkg::ADDR_W-1:0]      flash_wr_addr,
  output logic [fcl_pkg::WORD_W-1:0]      flash_wr_data,
  output logic                            cfg_wr_en,
  output logic                            cfg_rd_en,
  output logic [fcl_pkg::ADDR_W-1:0]      cfg_addr,
  output logic [fcl_pkg::WORD_W-1:0]      cfg_wr_data,
  input  wire logic [fcl_pkg::WORD_W-1:0] cfg_rd_data,
  input  wire logic [127:0]               dec_key,
  input  wire logic                       dual_boot_en,
  input  wire logic [7:0]                 exp_version,
  input  wire logic                       frozen_io_reconfig_en,
  output logic                            io_freeze,
  input  wire logic                       soft_error_check_en,
  input  wire logic                       user_logic_idle,
  input  wire logic                       sed_reload,
  input  wire logic                       sed_reload_ext,
  output logic                            sed_error,
  output logic                            crc_error,
  output logic                            user_mode,
  output fcl_pkg::fcl_sec_e               sec_state,
  output logic                            otp_mode,
  output logic                            clk_sel_error,
  input  wire logic [fcl_pkg::SEL_W-1:0]  osc_sel,
  output logic                            config_master_clock,
  output logic                            config_master_clock_tick,
  output logic                            fab_osc,
  output logic                            fab_osc_tick,
  output logic                            tag_out_valid,
  input  wire logic                       tag_out_ready,
  output logic [7:0]                      tag_out_data,
  output logic                            tag_busy
);
  typedef struct packed {
    fcl_pkg::fcl_fsm_e                fsm;
    fcl_pkg::fcl_sec_e                sec;
    logic [31:0]                      lock_key;
    logic                             otp;
    logic [fcl_pkg::IDX_W-1:0]        idx;
    logic [fcl_pkg::ADDR_W-1:0]       base;
    logic                             ext;
    logic                             tried_bak;
    logic                             enc;
    logic [31:0]                      crc;
    logic [31:0]                      sed_crc;
    logic [31:0]                      sed_ref;
    logic [fcl_pkg::SEL_W-1:0]        cm_sel;
    logic                             clk_err;
    logic                             crc_err;
    logic                             user;
    logic                             freeze;
    logic                             sed_err;
    logic                             rd_en;
    logic [fcl_pkg::ADDR_W-1:0]       rd_addr;
    logic                             cfg_we;
    logic                             cfg_re;
    logic [fcl_pkg::ADDR_W-1:0]       cfg_a;
    logic [31:0]                      cfg_d;
    logic                             fw_en;
    logic                             f_erase;
    logic [fcl_pkg::ADDR_W-1:0]       fw_addr;
    logic [31:0]                      fw_data;
    logic                             ack;
    logic                             refused;
    logic                             tag_act;
    logic [fcl_pkg::TAG_AW-1:0]       tag_ptr;
    logic [fcl_pkg::TAG_AW-1:0]       tag_cnt;
    logic                             tag_vld;
    logic [7:0]                       tag_dat;
  } fcl_st_s;

  fcl_st_s    st;
  fcl_st_s    next_st;
  logic [7:0] tag_mem [fcl_pkg::TAG_BYTES];
  logic       tag_we;
  logic [31:0] plain;

  // label memory byte array, written only by the label program command
  always_ff @(posedge sys_clk) begin
    if (tag_we) begin
      tag_mem[cmd.addr[fcl_pkg::TAG_AW-1:0]] <= cmd.data[7:0];
    end
  end

  // keystream stands in for the cipher core; key never leaves the chip
  assign plain = flash_rd_data ^ dec_key[32*st.idx[1:0] +: 32];

  always_comb begin
    logic       flash_ok;
    logic       ld_start;
    logic [7:0] ver;
    flash_ok = 1'b0;
    ld_start = 1'b0;
    ver      = flash_rd_data[fcl_pkg::HDR_VER_LSB +: 8];
    tag_we   = 1'b0;
    next_st  = st;
    next_st.ack     = 1'b0;
    next_st.refused = 1'b0;
    next_st.rd_en   = 1'b0;
    next_st.cfg_we  = 1'b0;
    next_st.cfg_re  = 1'b0;
    next_st.fw_en   = 1'b0;
    next_st.f_erase = 1'b0;

    // erase and program commands: flash changes only from the two external ports
    flash_ok = (cmd.port != fcl_pkg::PORT_FABRIC)
               && !st.otp
               && (st.sec == fcl_pkg::SEC_UNLOCKED);
    if (cmd_valid) begin
      next_st.ack = 1'b1;
      case (cmd.op)
        fcl_pkg::OP_ERASE, fcl_pkg::OP_PROG: begin
          if (flash_ok) begin
            next_st.fw_en   = cmd.op == fcl_pkg::OP_PROG;
            next_st.f_erase = cmd.op == fcl_pkg::OP_ERASE;
            next_st.fw_addr = cmd.addr;
            next_st.fw_data = cmd.data;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_WRITEBACK: begin
          if (!st.otp) begin
            next_st.fw_en   = 1'b1;
            next_st.fw_addr = fcl_pkg::EBR_BASE | cmd.addr;
            next_st.fw_data = cmd.data;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_LOAD: begin
          // master spi load is taken from the fabric-side start too
          if (st.fsm == fcl_pkg::ST_USER || st.fsm == fcl_pkg::ST_FAIL
              || st.fsm == fcl_pkg::ST_SED_RD
              || st.fsm == fcl_pkg::ST_SED_WAIT) begin
            ld_start   = 1'b1;
            next_st.ext = cmd.data[0];
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_KEY_LOCK: begin
          if (st.sec == fcl_pkg::SEC_UNLOCKED) begin
            next_st.sec      = fcl_pkg::SEC_KEY_LOCKED;
            next_st.lock_key = cmd.data;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_UNLOCK: begin
          if (st.sec == fcl_pkg::SEC_KEY_LOCKED
              && cmd.data == st.lock_key) begin
            next_st.sec = fcl_pkg::SEC_UNLOCKED;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_PERM_LOCK: next_st.sec = fcl_pkg::SEC_PERM_LOCKED;
        fcl_pkg::OP_SET_OTP:   next_st.otp = 1'b1;
        fcl_pkg::OP_TAG_PROG: begin
          // no security check at all on the label memory
          if (cmd.addr < fcl_pkg::ADDR_W'(fcl_pkg::TAG_BYTES)
              && !st.tag_act) begin
            tag_we = 1'b1;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        fcl_pkg::OP_TAG_READ: begin
          if (cmd.addr < fcl_pkg::ADDR_W'(fcl_pkg::TAG_BYTES)
              && !st.tag_act) begin
            next_st.tag_act = 1'b1;
            next_st.tag_ptr = cmd.addr[fcl_pkg::TAG_AW-1:0];
            next_st.tag_cnt = '0;
          end else begin
            next_st.refused = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // label stream: every byte once, wrapping past the top address
    if (!st.tag_vld || tag_out_ready) begin
      next_st.tag_vld = 1'b0;
      if (st.tag_act) begin
        next_st.tag_vld = 1'b1;
        next_st.tag_dat = tag_mem[st.tag_ptr];
        next_st.tag_ptr = (st.tag_ptr == fcl_pkg::TAG_LAST) ? '0
                          : st.tag_ptr + 7'h01;
        next_st.tag_cnt = st.tag_cnt + 7'h01;
        if (st.tag_cnt == fcl_pkg::TAG_LAST) next_st.tag_act = 1'b0;
      end
    end

    case (st.fsm)
      fcl_pkg::ST_RD: begin
        next_st.rd_en   = 1'b1;
        next_st.rd_addr = st.base + fcl_pkg::ADDR_W'(st.idx);
        next_st.fsm     = fcl_pkg::ST_WAIT;
      end
      fcl_pkg::ST_WAIT: begin
        if (flash_rd_valid) begin
          next_st.idx = st.idx + 5'h01;
          next_st.fsm = fcl_pkg::ST_RD;
          if (st.idx == '0) begin
            next_st.enc = flash_rd_data[fcl_pkg::HDR_ENC_BIT];
            next_st.crc = fcl_pkg::fcl_crc(fcl_pkg::CRC_INIT,
                                           flash_rd_data);
            next_st.sed_ref = fcl_pkg::CRC_INIT;
            if (flash_rd_data[fcl_pkg::SEL_W-1:0]
                <= fcl_pkg::CMCLK_SEL_MAX) begin
              next_st.cm_sel = flash_rd_data[fcl_pkg::SEL_W-1:0];
            end else begin
              next_st.clk_err = 1'b1;
            end
            if (dual_boot_en && !st.tried_bak && ver != exp_version) begin
              next_st.base      = fcl_pkg::BAK_BASE;
              next_st.tried_bak = 1'b1;
              next_st.idx       = '0;
            end
          end else if (st.idx != fcl_pkg::IMG_LAST) begin
            next_st.crc    = fcl_pkg::fcl_crc(st.crc, flash_rd_data);
            next_st.cfg_we = 1'b1;
            next_st.cfg_a  = fcl_pkg::ADDR_W'(st.idx - 5'h01);
            next_st.cfg_d  = st.enc ? plain : flash_rd_data;
            next_st.sed_ref = fcl_pkg::fcl_crc(st.sed_ref,
                                  st.enc ? plain : flash_rd_data);
          end else if (flash_rd_data == st.crc) begin
            next_st.fsm    = fcl_pkg::ST_USER;
            next_st.user   = 1'b1;
            next_st.freeze = 1'b0;
          end else if (dual_boot_en && !st.tried_bak) begin
            next_st.base      = fcl_pkg::BAK_BASE;
            next_st.tried_bak = 1'b1;
            next_st.idx       = '0;
          end else begin
            next_st.fsm     = fcl_pkg::ST_FAIL;
            next_st.crc_err = 1'b1;
          end
        end
      end
      fcl_pkg::ST_USER: begin
        if (soft_error_check_en && user_logic_idle) begin
          next_st.fsm     = fcl_pkg::ST_SED_RD;
          next_st.idx     = '0;
          next_st.sed_crc = fcl_pkg::CRC_INIT;
        end
      end
      fcl_pkg::ST_SED_RD: begin
        next_st.cfg_re = 1'b1;
        next_st.cfg_a  = fcl_pkg::ADDR_W'(st.idx);
        next_st.fsm    = fcl_pkg::ST_SED_WAIT;
      end
      fcl_pkg::ST_SED_WAIT: begin
        // cfg_rd_data is taken while the read strobe still stands
        next_st.sed_crc = fcl_pkg::fcl_crc(st.sed_crc, cfg_rd_data);
        next_st.idx     = st.idx + 5'h01;
        next_st.fsm     = fcl_pkg::ST_SED_RD;
        if (st.idx == fcl_pkg::PAY_LAST) begin
          next_st.fsm = fcl_pkg::ST_USER;
          if (next_st.sed_crc != st.sed_ref) begin
            if (sed_reload) begin
              ld_start    = 1'b1;
              next_st.ext = sed_reload_ext;
            end else begin
              next_st.sed_err = 1'b1;
            end
          end
        end
      end
      fcl_pkg::ST_FAIL: ;
      default: next_st.fsm = fcl_pkg::ST_FAIL;
    endcase

    // scan stops as soon as user logic wakes up
    if ((st.fsm == fcl_pkg::ST_SED_RD || st.fsm == fcl_pkg::ST_SED_WAIT)
        && !(soft_error_check_en && user_logic_idle) && !ld_start) begin
      next_st.fsm    = fcl_pkg::ST_USER;
      next_st.cfg_re = 1'b0;
    end

    if (ld_start) begin
      next_st.fsm       = fcl_pkg::ST_RD;
      next_st.idx       = '0;
      next_st.base      = fcl_pkg::PRI_BASE;
      next_st.tried_bak = 1'b0;
      next_st.crc_err   = 1'b0;
      next_st.user      = 1'b0;
      next_st.cfg_re    = 1'b0;
      next_st.freeze    = frozen_io_reconfig_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st        <= '0;
      st.fsm    <= fcl_pkg::ST_RD;
      st.sec    <= fcl_pkg::SEC_UNLOCKED;
      st.base   <= fcl_pkg::PRI_BASE;
      st.cm_sel <= fcl_pkg::CMCLK_SEL_RST;
    end else begin
      st <= next_st;
    end
  end

  // both dividers free-run and are exported to the fabric clock tree
  fcl_clk_div u_cmclk (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sel     (st.cm_sel),
    .clk_lvl (config_master_clock),
    .tick    (config_master_clock_tick)
  );

  fcl_clk_div u_fabosc (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sel     ((osc_sel > fcl_pkg::FREQ_SEL_MAX) ? fcl_pkg::OSC_SEL_RST
                                                : osc_sel),
    .clk_lvl (fab_osc),
    .tick    (fab_osc_tick)
  );

  assign cmd_ack       = st.ack;
  assign cmd_refused   = st.refused;
  assign flash_rd_en   = st.rd_en;
  assign flash_rd_addr = st.rd_addr;
  assign boot_ext      = st.ext;
  assign flash_wr_en   = st.fw_en;
  assign flash_erase   = st.f_erase;
  assign flash_wr_addr = st.fw_addr;
  assign flash_wr_data = st.fw_data;
  assign cfg_wr_en     = st.cfg_we;
  assign cfg_rd_en     = st.cfg_re;
  assign cfg_addr      = st.cfg_a;
  assign cfg_wr_data   = st.cfg_d;
  assign io_freeze     = st.freeze;
  assign sed_error     = st.sed_err;
  assign crc_error     = st.crc_err;
  assign user_mode     = st.user;
  assign sec_state     = st.sec;
  assign otp_mode      = st.otp;
  assign clk_sel_error = st.clk_err;
  assign tag_out_valid = st.tag_vld;
  assign tag_out_data  = st.tag_dat;
  assign tag_busy      = st.tag_act;
endmodule

// [testbench/fcl_loader_asserts.sv]
// checker: command answers, lock states and crc status of the loader
`timescale 1ns/1ps
module fcl_loader_asserts (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              cmd_valid,
  input wire fcl_pkg::fcl_cmd_s cmd,
  input wire logic              cmd_ack,
  input wire logic              cmd_refused,
  input wire logic              flash_wr_en,
  input wire logic              flash_erase,
  input wire fcl_pkg::fcl_sec_e sec_state,
  input wire logic              otp_mode,
  input wire logic              crc_error,
  input wire logic              user_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire fl_op = cmd_valid &&
               cmd.op inside {fcl_pkg::OP_ERASE, fcl_pkg::OP_PROG};
  wire no_wr = !flash_wr_en && !flash_erase;
  wire perm  = sec_state == fcl_pkg::SEC_PERM_LOCKED;
  ack_timing_a:
    assert property (cmd_valid |=> cmd_ack) else $error("no ack");
  ack_cause_a:
    assert property (cmd_ack |-> $past(cmd_valid)) else $error("stray ack");
  fabric_flash_a:
    assert property (fl_op && cmd.port == fcl_pkg::PORT_FABRIC |=>
      cmd_refused && no_wr) else $error("fabric flash write taken");
  otp_flash_a:
    assert property (fl_op && otp_mode |=> cmd_refused && no_wr)
      else $error("flash changed under otp");
  lock_flash_a:
    assert property (fl_op && sec_state != fcl_pkg::SEC_UNLOCKED |=> no_wr)
      else $error("flash changed while locked");
  perm_kept_a:
    assert property (perm |=> perm) else $error("permanent lock left");
  perm_unlock_a:
    assert property (perm && cmd_valid && cmd.op == fcl_pkg::OP_UNLOCK
      |=> cmd_refused) else $error("unlock taken while permanent");
  crc_user_a:
    assert property (crc_error |-> !user_mode) else $error("user on bad crc");
endmodule
bind fcl_loader fcl_loader_asserts fcl_loader_asserts_inst (.sys_clk, .rst_b,
  .cmd_valid, .cmd, .cmd_ack, .cmd_refused, .flash_wr_en, .flash_erase,
  .sec_state, .otp_mode, .crc_error, .user_mode);

// [testbench/fcl_flash_model.sv]
// partner: boot flash with prompt or slow answers, and config cells
`timescale 1ns/1ps
module fcl_flash_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        flash_rd_en,
  input  wire logic [11:0] flash_rd_addr,
  output logic      [31:0] flash_rd_data,
  output logic             flash_rd_valid,
  input  wire logic        cfg_wr_en,
  input  wire logic        cfg_rd_en,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [31:0] cfg_wr_data,
  output logic      [31:0] cfg_rd_data
);
  logic [31:0] mem [0:511];
  logic [31:0] cfg [0:15];
  logic [8:0]  addr;
  logic [1:0]  wait_n;
  // header, 14 payload words, then crc over the first 15 words
  task automatic build(logic [8:0] base, logic [7:0] ver, logic bad,
                       logic enc = 1'b0);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int w = 0; w < 16; w++) begin
      mem[base+w] = w == 0 ? {ver, 15'h0000, enc, 8'h01}
                  : w < 15 ? $urandom : c^32'(bad);
      for (int i = 31; i >= 0; i--)
        c = {c[30:0], 1'b0} ^ (c[31] ^ mem[base+w][i] ? 32'h04C11DB7 : 32'h0);
    end
  endtask
  // data flips every idle cycle so a stale word is never mistaken for valid
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_n         <= 2'h0;
      flash_rd_valid <= 1'b0;
    end else begin
      flash_rd_valid <= wait_n == 2'h1;
      flash_rd_data  <= wait_n == 2'h1 ? mem[addr] : ~flash_rd_data;
      if (flash_rd_en) begin
        addr   <= flash_rd_addr[8:0];
        wait_n <= slow ? 2'h3 : 2'h1;
      end else if (wait_n != 2'h0) begin
        wait_n <= wait_n - 2'h1;
      end
    end
  end
  always @(posedge sys_clk)
    if (cfg_wr_en)
      cfg[cfg_addr[3:0]] <= cfg_wr_data;
  // cells answer at once; the loader takes the word while the strobe stands
  assign cfg_rd_data = cfg_rd_en ? cfg[cfg_addr[3:0]] : ~cfg[cfg_addr[3:0]];
endmodule

// [testbench/fcl_loader_test.sv]
// bench: boot and fallback loads, command answers, label stream
`timescale 1ns/1ps
module fcl_loader_test;
  logic              sys_clk, rst_b, cmd_valid, slow, tag_out_ready, scan;
  logic              cmd_ack, cmd_refused, flash_rd_en, flash_rd_valid;
  logic              flash_wr_en, flash_erase, cfg_wr_en, cfg_rd_en;
  logic              io_freeze, sed_error, crc_error, user_mode;
  logic              tag_out_valid, tag_busy;
  logic [11:0]       flash_rd_addr, cfg_addr;
  logic [31:0]       flash_rd_data, cfg_wr_data, cfg_rd_data, key_w;
  logic [127:0]      dec_key;
  logic [4:0]        osc_sel;
  fcl_pkg::fcl_cmd_s cmd;
  logic [1:0]        exp_q[$];
  int                miscompares, checks, nbytes;
  fcl_loader fcl_loader_inst (.sys_clk, .rst_b, .cmd_valid, .cmd, .cmd_ack,
    .cmd_refused, .flash_rd_en, .flash_rd_addr, .flash_rd_data,
    .flash_rd_valid, .boot_ext(), .flash_wr_en, .flash_erase,
    .flash_wr_addr(), .flash_wr_data(), .cfg_wr_en, .cfg_rd_en, .cfg_addr,
    .cfg_wr_data, .cfg_rd_data, .dec_key, .dual_boot_en(1'b1),
    .exp_version(8'h11), .frozen_io_reconfig_en(1'b1), .io_freeze,
    .soft_error_check_en(scan), .user_logic_idle(scan), .sed_reload(1'b0),
    .sed_reload_ext(1'b0), .sed_error, .crc_error, .user_mode, .sec_state(),
    .otp_mode(), .clk_sel_error(), .osc_sel, .config_master_clock(),
    .config_master_clock_tick(), .fab_osc(), .fab_osc_tick(),
    .tag_out_valid, .tag_out_ready, .tag_out_data(), .tag_busy);
  fcl_flash_model fcl_flash_model_inst (.sys_clk, .rst_b, .slow, .flash_rd_en,
    .flash_rd_addr, .flash_rd_data, .flash_rd_valid, .cfg_wr_en, .cfg_rd_en,
    .cfg_addr, .cfg_wr_data, .cfg_rd_data);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // note holds {refused, flash write or erase beside the ack}
  task automatic cmd_do(logic [3:0] op, logic [1:0] port, logic [1:0] exp,
                        logic [31:0] bad = 32'h0);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd.op    <= fcl_pkg::fcl_op_e'(op);
    cmd.port  <= fcl_pkg::fcl_port_e'(port);
    cmd.addr  <= 12'($urandom % 75);
    cmd.data  <= (op == 4'h5 || op == 4'h6) ? key_w ^ bad : $urandom;
    exp_q.push_back(exp);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_load(logic [1:0] exp, logic fz = 1'b1);
    repeat (3) @(posedge sys_clk);
    #1 check("freeze", 8'(io_freeze), 8'(fz));
    for (int i = 0; i < 1500 && user_mode !== 1'b1 && crc_error !== 1'b1; i++)
      @(posedge sys_clk) #1;
    check("load", 8'({user_mode, crc_error}), 8'(exp));
  endtask
  always @(posedge sys_clk) begin
    if (cmd_ack === 1'b1)
      check("answer", 8'({cmd_refused, flash_wr_en | flash_erase}),
            8'(exp_q.size() > 0 ? exp_q.pop_front() : 2'h3));
    if (tag_out_valid === 1'b1 && tag_out_ready)
      nbytes++;
    tag_out_ready <= 1'($urandom);
    osc_sel       <= 5'($urandom % 17);
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(5704));
    rst_b = 1'b0;
    {cmd_valid, cmd, slow, scan} = '0;
    dec_key = {$urandom, $urandom, $urandom, $urandom};
    key_w = $urandom;
    fcl_flash_model_inst.build(9'h000, 8'h11, 1'b0);
    fcl_flash_model_inst.build(9'h100, 8'h11, 1'b0);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_load(2'b10, 1'b0);
    fcl_flash_model_inst.build(9'h000, 8'h22, 1'b0);
    slow <= 1'b1;
    cmd_do(4'h4, 2'h0, 2'b00);
    wait_load(2'b10);
    fcl_flash_model_inst.build(9'h000, 8'h11, 1'b1);
    fcl_flash_model_inst.build(9'h100, 8'h11, 1'b1);
    cmd_do(4'h4, 2'h0, 2'b00);
    wait_load(2'b01);
    fcl_flash_model_inst.build(9'h000, 8'h11, 1'b0, 1'b1);
    cmd_do(4'h4, 2'h1, 2'b00);
    wait_load(2'b10);
    check("decrypt", fcl_flash_model_inst.cfg[0][7:0],
          fcl_flash_model_inst.mem[1][7:0] ^ dec_key[39:32]);
    scan <= 1'b1;
    cmd_do(4'h2, 2'h0, 2'b01);
    cmd_do(4'h1, 2'h1, 2'b01);
    cmd_do(4'h2, 2'h2, 2'b10);
    cmd_do(4'h3, 2'h2, 2'b01);
    cmd_do(4'h6, 2'h0, 2'b00);
    cmd_do(4'h2, 2'h0, 2'b10);
    cmd_do(4'h5, 2'h0, 2'b10, 32'h1);
    cmd_do(4'h5, 2'h0, 2'b00);
    cmd_do(4'h8, 2'h0, 2'b00);
    cmd_do(4'h1, 2'h0, 2'b10);
    cmd_do(4'h3, 2'h0, 2'b10);
    cmd_do(4'h7, 2'h0, 2'b00);
    cmd_do(4'h5, 2'h0, 2'b10);
    cmd_do(4'hA, 2'h2, 2'b00);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 1000 && (tag_busy | tag_out_valid) !== 1'b0; i++)
      @(posedge sys_clk) #1;
    check("label bytes", 8'(nbytes), 8'd75);
    check("scan clean", 8'(sed_error), 8'h00);
    complete_run();
  end
endmodule
